// ---- src/mcu_exec_defs.svh ----
// constants for the instruction cycle and flag unit
// assumes inclusion by bare name from the package and the unit
`ifndef MCU_EXEC_DEFS_SVH
`define MCU_EXEC_DEFS_SVH

`define MCU_DATA_W      8
`define MCU_BIT_SEL_W   3
`define MCU_ROM_W       15
`define MCU_TBL_HIGH_W  7
`define MCU_OP_W        6
`define MCU_CYC_SHORT   1
`define MCU_CYC_LONG    2
`define MCU_DATA_ZERO   8'h00
`define MCU_DATA_ONE    8'h01
`define MCU_TBL_RESET   7'h00
`define MCU_NIB_W       4

`endif

// ---- src/mcu_exec_pkg.sv ----
// types for the instruction cycle and flag unit
// assumes mcu_exec_defs.svh is on the include path
`include "mcu_exec_defs.svh"

package mcu_exec_pkg;

  typedef enum logic [`MCU_OP_W-1:0] {
    OP_NOP                       = 6'b000000,
    OP_ROTATE_RIGHT_TO_ACC       = 6'b000001,
    OP_ROTATE_RIGHT_MEM          = 6'b000010,
    OP_ROTATE_RIGHT_CARRY_TO_ACC = 6'b000011,
    OP_ROTATE_RIGHT_CARRY_MEM    = 6'b000100,
    OP_ROTATE_LEFT_TO_ACC        = 6'b000101,
    OP_ROTATE_LEFT_MEM           = 6'b000110,
    OP_ROTATE_LEFT_CARRY_TO_ACC  = 6'b000111,
    OP_ROTATE_LEFT_CARRY_MEM     = 6'b001000,
    OP_COPY_DATA_MEM_TO_ACC      = 6'b001001,
    OP_COPY_DATA_ACC_TO_MEM      = 6'b001010,
    OP_COPY_DATA_IMM_TO_ACC      = 6'b001011,
    OP_BIT_CLEAR                 = 6'b001100,
    OP_BIT_SET                   = 6'b001101,
    OP_JUMP_ABSOLUTE             = 6'b001110,
    OP_SUBROUTINE_INVOKE         = 6'b001111,
    OP_SUBROUTINE_EXIT           = 6'b010000,
    OP_SUBROUTINE_EXIT_IMM       = 6'b010001,
    OP_INTERRUPT_EXIT            = 6'b010010,
    OP_SKIP_ON_ZERO              = 6'b010011,
    OP_SKIP_ON_ZERO_COPY_ACC     = 6'b010100,
    OP_SKIP_ON_BIT_CLEAR         = 6'b010101,
    OP_SKIP_ON_BIT_SET           = 6'b010110,
    OP_INCREMENT_SKIP_ZERO       = 6'b010111,
    OP_DECREMENT_SKIP_ZERO       = 6'b011000,
    OP_INCREMENT_SKIP_ZERO_ACC   = 6'b011001,
    OP_DECREMENT_SKIP_ZERO_ACC   = 6'b011010,
    OP_TABLE_FETCH_CURRENT_PAGE  = 6'b011011,
    OP_TABLE_FETCH_FINAL_PAGE    = 6'b011100,
    OP_WATCHDOG_CLEAR_CMD        = 6'b011101,
    OP_WATCHDOG_PRECLEAR_FIRST   = 6'b011110,
    OP_WATCHDOG_PRECLEAR_SECOND  = 6'b011111,
    OP_NIBBLE_EXCHANGE_MEM       = 6'b100000,
    OP_NIBBLE_EXCHANGE_TO_ACC    = 6'b100001,
    OP_ENTER_POWERDOWN           = 6'b100010,
    OP_CLEAR_MEM                 = 6'b100011,
    OP_SET_MEM                   = 6'b100100
  } op_t;

  typedef enum logic [1:0] {
    ST_READY  = 2'b00,
    ST_EXTRA  = 2'b01,
    ST_TABLE  = 2'b10,
    ST_HALTED = 2'b11
  } exec_state_t;

  typedef enum logic [1:0] {
    PRE_NONE   = 2'b00,
    PRE_FIRST  = 2'b01,
    PRE_SECOND = 2'b10
  } preclear_t;

endpackage

// ---- src/mcu_exec_unit.sv ----
// instruction cycle, flag and watchdog-flag unit of an 8-bit core
// assumes all inputs come from logic on i_clk; the pc, data memory,
// program memory and watchdog counter live outside this unit
//
// Operation
// - plain rotates right or left to acc or memory take one cycle and touch no flag.
// - rotates through carry take one cycle, go to acc or memory and update only carry.
// - memory to acc, acc to memory and immediate to acc moves take one cycle, no flags.
// - bit set or clear of a memory byte takes one cycle and keeps other bits and flags.
// - jump, invoke, subroutine exit, exit with immediate and interrupt exit take two cycles.
// - skip when a byte is zero, also when copying it to acc, or on a chosen bit clear or set.
// - increment or decrement with skip on zero, into memory or into acc, changes no flag.
// - a conditional skip takes two cycles when it skips and one when it does not.
// - any instruction that writes the pc low byte takes two cycles.
// - table fetches from current or final page take two cycles, high part to latch, low to memory.
// - the pre-clear pair clears the expired and power-down flags only when run back to back.
// - nibble exchange goes in place or to acc with no flag change.
// - enter-power-down takes one cycle and affects only the expired and power-down flags.
// - power-down stops execution, keeps state, clears the watchdog, sets pd and clears expired.
// - the plain watchdog clear resets the counter and clears both flags.
`timescale 1ns/1ps
`include "mcu_exec_defs.svh"

module mcu_exec_unit (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_op_valid,
  input  wire logic [`MCU_OP_W-1:0]        i_op,
  input  wire logic [`MCU_DATA_W-1:0]      i_mem_rdata,
  input  wire logic [`MCU_DATA_W-1:0]      i_imm,
  input  wire logic [`MCU_BIT_SEL_W-1:0]   i_bit_sel,
  input  wire logic                        i_dest_is_pc_low_byte,
  input  wire logic [`MCU_ROM_W-1:0]       i_rom_word,
  input  wire logic                        i_wdt_timeout,
  input  wire logic                        i_wake,
  output logic                             o_ready,
  output logic [`MCU_DATA_W-1:0]           o_acc,
  output logic                             o_carry,
  output logic                             o_mem_we,
  output logic [`MCU_DATA_W-1:0]           o_mem_wdata,
  output logic                             o_skip_next,
  output logic                             o_rom_rd,
  output logic                             o_rom_final_page,
  output logic [`MCU_TBL_HIGH_W-1:0]       o_table_high_latch,
  output logic                             o_wdt_clear,
  output logic                             o_watchdog_expired_flag,
  output logic                             o_powerdown_flag,
  output logic                             o_halted
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // nine-bit rotate: {carry_out, byte}
  function automatic logic [`MCU_DATA_W:0] rot_carry(
    input logic [`MCU_DATA_W-1:0] d,
    input logic                   c,
    input logic                   left);
    if (left) begin
      rot_carry = {d[`MCU_DATA_W-1], d[`MCU_DATA_W-2:0], c};
    end else begin
      rot_carry = {d[0], c, d[`MCU_DATA_W-1:1]};
    end
  endfunction

  function automatic logic is_zero(input logic [`MCU_DATA_W-1:0] d);
    is_zero = (d == `MCU_DATA_ZERO);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  mcu_exec_pkg::exec_state_t     state_ff, nxt_state;
  mcu_exec_pkg::preclear_t       pre_ff, nxt_pre;
  logic [`MCU_DATA_W-1:0]        acc_ff, nxt_acc;
  logic                          carry_ff, nxt_carry;
  logic                          mem_we_ff, nxt_mem_we;
  logic [`MCU_DATA_W-1:0]        mem_wdata_ff, nxt_mem_wdata;
  logic                          skip_ff, nxt_skip;
  logic                          rom_rd_ff, nxt_rom_rd;
  logic                          rom_final_ff, nxt_rom_final;
  logic [`MCU_TBL_HIGH_W-1:0]    tbl_high_ff, nxt_tbl_high;
  logic                          wdt_clear_ff, nxt_wdt_clear;
  logic                          expired_ff, nxt_expired;
  logic                          pd_ff, nxt_pd;

  logic                          take;
  logic [`MCU_DATA_W:0]          rot;
  logic [`MCU_DATA_W-1:0]        bit_mask;
  logic [`MCU_DATA_W-1:0]        inc_val;
  logic [`MCU_DATA_W-1:0]        dec_val;
  logic                          long_op;

  assign take     = i_op_valid && (state_ff == mcu_exec_pkg::ST_READY);
  assign bit_mask = `MCU_DATA_ONE << i_bit_sel;
  assign inc_val  = i_mem_rdata + `MCU_DATA_ONE;
  assign dec_val  = i_mem_rdata - `MCU_DATA_ONE;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state     = state_ff;
    nxt_pre       = pre_ff;
    nxt_acc       = acc_ff;
    nxt_carry     = carry_ff;
    nxt_mem_we    = 1'b0;
    nxt_mem_wdata = mem_wdata_ff;
    nxt_skip      = 1'b0;
    nxt_rom_rd    = 1'b0;
    nxt_rom_final = rom_final_ff;
    nxt_tbl_high  = tbl_high_ff;
    nxt_wdt_clear = 1'b0;
    nxt_expired   = expired_ff;
    nxt_pd        = pd_ff;
    rot           = {1'b0, `MCU_DATA_ZERO};
    long_op       = 1'b0;

    case (state_ff)
      mcu_exec_pkg::ST_READY: begin
        if (take) begin
          nxt_pre = mcu_exec_pkg::PRE_NONE;
          case (mcu_exec_pkg::op_t'(i_op))
            mcu_exec_pkg::OP_ROTATE_RIGHT_TO_ACC: begin
              nxt_acc = {i_mem_rdata[0], i_mem_rdata[`MCU_DATA_W-1:1]};
            end
            mcu_exec_pkg::OP_ROTATE_RIGHT_MEM: begin
              nxt_mem_we    = 1'b1;
              nxt_mem_wdata = {i_mem_rdata[0],
                               i_mem_rdata[`MCU_DATA_W-1:1]};
            end
            mcu_exec_pkg::OP_ROTATE_LEFT_TO_ACC: begin
              nxt_acc = {i_mem_rdata[`MCU_DATA_W-2:0],
                         i_mem_rdata[`MCU_DATA_W-1]};
            end
            mcu_exec_pkg::OP_ROTATE_LEFT_MEM: begin
              nxt_mem_we    = 1'b1;
              nxt_mem_wdata = {i_mem_rdata[`MCU_DATA_W-2:0],
                               i_mem_rdata[`MCU_DATA_W-1]};
            end
            mcu_exec_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACC,
            mcu_exec_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC: begin
              rot = rot_carry(i_mem_rdata, carry_ff,
                i_op == mcu_exec_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC);
              nxt_carry = rot[`MCU_DATA_W];
              nxt_acc   = rot[`MCU_DATA_W-1:0];
            end
            mcu_exec_pkg::OP_ROTATE_RIGHT_CARRY_MEM,
            mcu_exec_pkg::OP_ROTATE_LEFT_CARRY_MEM: begin
              rot = rot_carry(i_mem_rdata, carry_ff,
                i_op == mcu_exec_pkg::OP_ROTATE_LEFT_CARRY_MEM);
              nxt_carry     = rot[`MCU_DATA_W];
              nxt_mem_we    = 1'b1;
              nxt_mem_wdata = rot[`MCU_DATA_W-1:0];
            end
            mcu_exec_pkg::OP_COPY_DATA_MEM_TO_ACC: begin
              nxt_acc = i_mem_rdata;
            end
            mcu_exec_pkg::OP_COPY_DATA_IMM_TO_ACC: begin
              nxt_acc = i_imm;
            end
            mcu_exec_pkg::OP_COPY_DATA_ACC_TO_MEM: begin
              nxt_mem_we    = 1'b1;
              nxt_mem_wdata = acc_ff;
            end
            mcu_exec_pkg::OP_BIT_CLEAR: begin
              nxt_mem_we    = 1'b1;
              nxt_mem_wdata = i_mem_rdata & ~bit_mask;
            end
            mcu_exec_pkg::OP_BIT_SET: begin
              nxt_mem_we    = 1'b1;
              nxt_mem_wdata = i_mem_rdata | bit_mask;
            end
            mcu_exec_pkg::OP_CLEAR_MEM: begin
              nxt_mem_we    = 1'b1;
              nxt_mem_wdata = `MCU_DATA_ZERO;
            end
            mcu_exec_pkg::OP_SET_MEM: begin
              nxt_mem_we    = 1'b1;
              nxt_mem_wdata = ~`MCU_DATA_ZERO;
            end
            mcu_exec_pkg::OP_JUMP_ABSOLUTE,
            mcu_exec_pkg::OP_SUBROUTINE_INVOKE,
            mcu_exec_pkg::OP_SUBROUTINE_EXIT,
            mcu_exec_pkg::OP_INTERRUPT_EXIT: begin
              long_op = 1'b1;
            end
            mcu_exec_pkg::OP_SUBROUTINE_EXIT_IMM: begin
              nxt_acc = i_imm;
              long_op = 1'b1;
            end
            mcu_exec_pkg::OP_SKIP_ON_ZERO: begin
              nxt_skip = is_zero(i_mem_rdata);
            end
            mcu_exec_pkg::OP_SKIP_ON_ZERO_COPY_ACC: begin
              nxt_acc  = i_mem_rdata;
              nxt_skip = is_zero(i_mem_rdata);
            end
            mcu_exec_pkg::OP_SKIP_ON_BIT_CLEAR: begin
              nxt_skip = is_zero(i_mem_rdata & bit_mask);
            end
            mcu_exec_pkg::OP_SKIP_ON_BIT_SET: begin
              nxt_skip = !is_zero(i_mem_rdata & bit_mask);
            end
            mcu_exec_pkg::OP_INCREMENT_SKIP_ZERO: begin
              nxt_mem_we    = 1'b1;
              nxt_mem_wdata = inc_val;
              nxt_skip      = is_zero(inc_val);
            end
            mcu_exec_pkg::OP_DECREMENT_SKIP_ZERO: begin
              nxt_mem_we    = 1'b1;
              nxt_mem_wdata = dec_val;
              nxt_skip      = is_zero(dec_val);
            end
            mcu_exec_pkg::OP_INCREMENT_SKIP_ZERO_ACC: begin
              nxt_acc  = inc_val;
              nxt_skip = is_zero(inc_val);
            end
            mcu_exec_pkg::OP_DECREMENT_SKIP_ZERO_ACC: begin
              nxt_acc  = dec_val;
              nxt_skip = is_zero(dec_val);
            end
            mcu_exec_pkg::OP_TABLE_FETCH_CURRENT_PAGE,
            mcu_exec_pkg::OP_TABLE_FETCH_FINAL_PAGE: begin
              nxt_rom_rd    = 1'b1;
              nxt_rom_final =
                (i_op == mcu_exec_pkg::OP_TABLE_FETCH_FINAL_PAGE);
              nxt_state     = mcu_exec_pkg::ST_TABLE;
            end
            mcu_exec_pkg::OP_WATCHDOG_CLEAR_CMD: begin
              nxt_wdt_clear = 1'b1;
              nxt_expired   = 1'b0;
              nxt_pd        = 1'b0;
            end
            mcu_exec_pkg::OP_WATCHDOG_PRECLEAR_FIRST: begin
              if (pre_ff == mcu_exec_pkg::PRE_SECOND) begin
                nxt_wdt_clear = 1'b1;
                nxt_expired   = 1'b0;
                nxt_pd        = 1'b0;
              end else begin
                nxt_pre = mcu_exec_pkg::PRE_FIRST;
              end
            end
            mcu_exec_pkg::OP_WATCHDOG_PRECLEAR_SECOND: begin
              if (pre_ff == mcu_exec_pkg::PRE_FIRST) begin
                nxt_wdt_clear = 1'b1;
                nxt_expired   = 1'b0;
                nxt_pd        = 1'b0;
              end else begin
                nxt_pre = mcu_exec_pkg::PRE_SECOND;
              end
            end
            mcu_exec_pkg::OP_NIBBLE_EXCHANGE_MEM: begin
              nxt_mem_we    = 1'b1;
              nxt_mem_wdata = {i_mem_rdata[`MCU_NIB_W-1:0],
                               i_mem_rdata[`MCU_DATA_W-1:`MCU_NIB_W]};
            end
            mcu_exec_pkg::OP_NIBBLE_EXCHANGE_TO_ACC: begin
              nxt_acc = {i_mem_rdata[`MCU_NIB_W-1:0],
                         i_mem_rdata[`MCU_DATA_W-1:`MCU_NIB_W]};
            end
            mcu_exec_pkg::OP_ENTER_POWERDOWN: begin
              nxt_wdt_clear = 1'b1;
              nxt_expired   = 1'b0;
              nxt_pd        = 1'b1;
              nxt_state     = mcu_exec_pkg::ST_HALTED;
            end
            default: begin
              nxt_acc = acc_ff;
            end
          endcase
          // a write to the pc low byte costs an extra cycle
          if (nxt_mem_we && i_dest_is_pc_low_byte) begin
            long_op = 1'b1;
          end
          if (long_op || nxt_skip) begin
            nxt_state = mcu_exec_pkg::ST_EXTRA;
          end
        end
      end
      mcu_exec_pkg::ST_EXTRA: begin
        nxt_state = mcu_exec_pkg::ST_READY;
      end
      mcu_exec_pkg::ST_TABLE: begin
        nxt_tbl_high  = i_rom_word[`MCU_ROM_W-1:`MCU_DATA_W];
        nxt_mem_we    = 1'b1;
        nxt_mem_wdata = i_rom_word[`MCU_DATA_W-1:0];
        nxt_state     = mcu_exec_pkg::ST_READY;
      end
      mcu_exec_pkg::ST_HALTED: begin
        if (i_wake || i_wdt_timeout) begin
          nxt_state = mcu_exec_pkg::ST_READY;
        end
      end
      default: begin
        nxt_state = mcu_exec_pkg::ST_READY;
      end
    endcase

    // a timeout in the same cycle as a clear still sets the flag
    if (i_wdt_timeout) begin
      nxt_expired = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_ff     <= mcu_exec_pkg::ST_READY;
      pre_ff       <= mcu_exec_pkg::PRE_NONE;
      acc_ff       <= `MCU_DATA_ZERO;
      carry_ff     <= 1'b0;
      mem_we_ff    <= 1'b0;
      mem_wdata_ff <= `MCU_DATA_ZERO;
      skip_ff      <= 1'b0;
      rom_rd_ff    <= 1'b0;
      rom_final_ff <= 1'b0;
      tbl_high_ff  <= `MCU_TBL_RESET;
      wdt_clear_ff <= 1'b0;
      expired_ff   <= 1'b0;
      pd_ff        <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      pre_ff       <= nxt_pre;
      acc_ff       <= nxt_acc;
      carry_ff     <= nxt_carry;
      mem_we_ff    <= nxt_mem_we;
      mem_wdata_ff <= nxt_mem_wdata;
      skip_ff      <= nxt_skip;
      rom_rd_ff    <= nxt_rom_rd;
      rom_final_ff <= nxt_rom_final;
      tbl_high_ff  <= nxt_tbl_high;
      wdt_clear_ff <= nxt_wdt_clear;
      expired_ff   <= nxt_expired;
      pd_ff        <= nxt_pd;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_ready                 = (state_ff == mcu_exec_pkg::ST_READY);
  assign o_halted                = (state_ff == mcu_exec_pkg::ST_HALTED);
  assign o_acc                   = acc_ff;
  assign o_carry                 = carry_ff;
  assign o_mem_we                = mem_we_ff;
  assign o_mem_wdata             = mem_wdata_ff;
  assign o_skip_next             = skip_ff;
  assign o_rom_rd                = rom_rd_ff;
  assign o_rom_final_page        = rom_final_ff;
  assign o_table_high_latch      = tbl_high_ff;
  assign o_wdt_clear             = wdt_clear_ff;
  assign o_watchdog_expired_flag = expired_ff;
  assign o_powerdown_flag        = pd_ff;

endmodule

// ---- verification/mcu_exec_unit_sva.sv ----
// checker for the instruction cycle and flag unit
// assumes it is bound to mcu_exec_unit and sees only its ports
`timescale 1ns/1ps
`include "mcu_exec_defs.svh"

module mcu_exec_unit_chk (
  input wire logic                      i_clk,
  input wire logic                      i_rst_n,
  input wire logic                      i_op_valid,
  input wire logic [`MCU_OP_W-1:0]      i_op,
  input wire logic [`MCU_DATA_W-1:0]    i_mem_rdata,
  input wire logic [`MCU_DATA_W-1:0]    i_imm,
  input wire logic [`MCU_BIT_SEL_W-1:0] i_bit_sel,
  input wire logic                      i_dest_is_pc_low_byte,
  input wire logic [`MCU_ROM_W-1:0]     i_rom_word,
  input wire logic                      i_wdt_timeout,
  input wire logic                      o_ready,
  input wire logic [`MCU_DATA_W-1:0]    o_acc,
  input wire logic                      o_carry,
  input wire logic                      o_mem_we,
  input wire logic [`MCU_DATA_W-1:0]    o_mem_wdata,
  input wire logic                      o_skip_next,
  input wire logic                      o_rom_rd,
  input wire logic                      o_rom_final_page,
  input wire logic [`MCU_TBL_HIGH_W-1:0] o_table_high_latch,
  input wire logic                      o_wdt_clear,
  input wire logic                      o_watchdog_expired_flag,
  input wire logic                      o_powerdown_flag,
  input wire logic                      o_halted
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire take = i_op_valid && o_ready;

  rotr_acc_a: assert property (take && i_op == mcu_exec_pkg::OP_ROTATE_RIGHT_TO_ACC |=> o_acc == {$past(i_mem_rdata[0]), $past(i_mem_rdata[7:1])} && $stable(o_carry)) else $error("plain rotate result or carry wrong");
  rotl_carry_a: assert property (take && i_op == mcu_exec_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC |=> o_acc == {$past(i_mem_rdata[6:0]), $past(o_carry)} && o_carry == $past(i_mem_rdata[7])) else $error("rotate through carry wrong");
  copy_imm_a: assert property (take && i_op == mcu_exec_pkg::OP_COPY_DATA_IMM_TO_ACC |=> o_acc == $past(i_imm) && $stable(o_carry)) else $error("immediate copy wrong");
  bit_set_a: assert property (take && i_op == mcu_exec_pkg::OP_BIT_SET |=> o_mem_we && o_mem_wdata == ($past(i_mem_rdata) | (8'h01 << $past(i_bit_sel)))) else $error("bit set result wrong");
  jump_stall_a: assert property (take && i_op == mcu_exec_pkg::OP_JUMP_ABSOLUTE |=> !o_ready ##1 o_ready) else $error("jump not two cycles");
  skip_taken_a: assert property (take && i_op == mcu_exec_pkg::OP_SKIP_ON_ZERO && i_mem_rdata == 8'h00 |=> o_skip_next && !o_ready ##1 o_ready) else $error("taken skip not two cycles");
  skip_not_a: assert property (take && i_op == mcu_exec_pkg::OP_SKIP_ON_ZERO && i_mem_rdata != 8'h00 |=> !o_skip_next && o_ready) else $error("untaken skip wrong");
  pcl_stall_a: assert property (take && i_op == mcu_exec_pkg::OP_COPY_DATA_ACC_TO_MEM && i_dest_is_pc_low_byte |=> !o_ready) else $error("pc low write not two cycles");
  table_fetch_a: assert property (take && i_op == mcu_exec_pkg::OP_TABLE_FETCH_CURRENT_PAGE |=> o_rom_rd && !o_rom_final_page ##1 o_mem_we && o_mem_wdata == $past(i_rom_word[7:0]) && o_table_high_latch == $past(i_rom_word[14:8])) else $error("table fetch wrong");
  halt_flags_a: assert property (take && i_op == mcu_exec_pkg::OP_ENTER_POWERDOWN && !i_wdt_timeout |=> o_powerdown_flag && !o_watchdog_expired_flag && o_halted && o_wdt_clear) else $error("power-down entry wrong");
  plain_clear_a: assert property (take && i_op == mcu_exec_pkg::OP_WATCHDOG_CLEAR_CMD && !i_wdt_timeout |=> !o_powerdown_flag && !o_watchdog_expired_flag && o_wdt_clear) else $error("watchdog clear wrong");
endmodule

bind mcu_exec_unit mcu_exec_unit_chk mcu_exec_unit_chk_inst (.*);

// ---- verification/tb_top.sv ----
// self-checking bench for the instruction cycle and flag unit
// assumes inputs change at the falling edge and results are read there
`timescale 1ns/1ps
`include "mcu_exec_defs.svh"

module tb_top;
  logic       i_clk = 1'b0, i_rst_n = 1'b0, vld = 1'b0, pc_low_byte = 1'b0;
  logic [5:0] op = 6'h00;
  logic [7:0] rd = 8'h00, imm = 8'h00;
  logic [2:0] bs = 3'h0;
  logic [14:0] rom = 15'h0000;
  logic       tmo = 1'b0, wake = 1'b0;
  logic       rdy, cy, we, skp, rrd, fpg, wclr, exf, powerdown_flag, hlt;
  logic [7:0] acc, wd;
  logic [6:0] lat;
  int         miscompares = 0, checked = 0;
  `define CHK(g, e) check_val(32'(g), 32'(e));

  mcu_exec_unit mcu_exec_unit_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_op_valid(vld), .i_op(op),
    .i_mem_rdata(rd), .i_imm(imm), .i_bit_sel(bs),
    .i_dest_is_pc_low_byte(pc_low_byte), .i_rom_word(rom), .i_wdt_timeout(tmo),
    .i_wake(wake), .o_ready(rdy), .o_acc(acc), .o_carry(cy),
    .o_mem_we(we), .o_mem_wdata(wd), .o_skip_next(skp), .o_rom_rd(rrd),
    .o_rom_final_page(fpg), .o_table_high_latch(lat), .o_wdt_clear(wclr),
    .o_watchdog_expired_flag(exf), .o_powerdown_flag(powerdown_flag), .o_halted(hlt));

  initial begin
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask

  // one instruction, results read at the falling edge after it is taken
  task automatic exec(input logic [5:0] o, input logic [7:0] d);
    @(negedge i_clk);
    vld = 1'b1;
    op = o;
    rd = d;
    @(negedge i_clk);
    vld = 1'b0;
  endtask

  task automatic t_rotate();
    exec(mcu_exec_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC, 8'h81);
    `CHK(acc, 8'h02) `CHK(cy, 1'b1)
    exec(mcu_exec_pkg::OP_ROTATE_RIGHT_TO_ACC, 8'h81);
    `CHK(acc, 8'hc0) `CHK(cy, 1'b1)
    exec(mcu_exec_pkg::OP_ROTATE_RIGHT_CARRY_MEM, 8'h02);
    `CHK({we, wd}, 9'h181) `CHK(cy, 1'b0)
    exec(mcu_exec_pkg::OP_ROTATE_LEFT_MEM, 8'h81);
    `CHK({we, wd, cy, rdy}, 11'h40d)
    $display("test rotate done");
  endtask

  task automatic t_move_bits();
    imm = 8'h5a;
    exec(mcu_exec_pkg::OP_COPY_DATA_IMM_TO_ACC, 8'h00);
    `CHK(acc, 8'h5a)
    exec(mcu_exec_pkg::OP_COPY_DATA_MEM_TO_ACC, 8'h33);
    `CHK({we, acc, cy}, 10'h066)
    exec(mcu_exec_pkg::OP_COPY_DATA_ACC_TO_MEM, 8'h00);
    `CHK({we, wd, rdy}, 10'h267)
    bs = 3'h7;
    exec(mcu_exec_pkg::OP_BIT_SET, 8'h01);
    `CHK({we, wd}, 9'h181)
    bs = 3'h0;
    exec(mcu_exec_pkg::OP_BIT_CLEAR, 8'hff);
    `CHK({we, wd, cy}, 10'h3fc)
    exec(mcu_exec_pkg::OP_NIBBLE_EXCHANGE_TO_ACC, 8'h3c);
    `CHK({we, acc}, 9'h0c3)
    $display("test move and bits done");
  endtask

  task automatic t_branch();
    logic [5:0] ops [5];
    ops = '{mcu_exec_pkg::OP_JUMP_ABSOLUTE, mcu_exec_pkg::OP_SUBROUTINE_INVOKE,
            mcu_exec_pkg::OP_SUBROUTINE_EXIT, mcu_exec_pkg::OP_INTERRUPT_EXIT,
            mcu_exec_pkg::OP_SUBROUTINE_EXIT_IMM};
    imm = 8'ha7;
    foreach (ops[k]) begin
      exec(ops[k], 8'h00);
      `CHK({rdy, cy}, 2'b00)
      @(negedge i_clk);
      `CHK(rdy, 1'b1)
    end
    `CHK(acc, 8'ha7)
    $display("test branch done");
  endtask

  task automatic skip_case(input logic [5:0] o, input logic [7:0] d,
                           input logic s);
    exec(o, d);
    `CHK({skp, rdy, cy}, {s, ~s, 1'b0})
    if (s) begin
      @(negedge i_clk);
    end
  endtask

  task automatic t_skip();
    skip_case(mcu_exec_pkg::OP_SKIP_ON_ZERO, 8'h00, 1'b1);
    skip_case(mcu_exec_pkg::OP_SKIP_ON_ZERO, 8'h10, 1'b0);
    skip_case(mcu_exec_pkg::OP_SKIP_ON_ZERO_COPY_ACC, 8'h00, 1'b1);
    `CHK(acc, 8'h00)
    bs = 3'h3;
    skip_case(mcu_exec_pkg::OP_SKIP_ON_BIT_SET, 8'h08, 1'b1);
    skip_case(mcu_exec_pkg::OP_SKIP_ON_BIT_CLEAR, 8'h08, 1'b0);
    skip_case(mcu_exec_pkg::OP_INCREMENT_SKIP_ZERO, 8'hff, 1'b1);
    skip_case(mcu_exec_pkg::OP_DECREMENT_SKIP_ZERO_ACC, 8'h05, 1'b0);
    `CHK({we, acc}, 9'h004)
    pc_low_byte = 1'b1;
    exec(mcu_exec_pkg::OP_COPY_DATA_ACC_TO_MEM, 8'h00);
    `CHK({we, rdy}, 2'b10)
    pc_low_byte = 1'b0;
    @(negedge i_clk);
    `CHK(rdy, 1'b1)
    $display("test skip done");
  endtask

  task automatic t_table();
    rom = 15'h7abc;
    exec(mcu_exec_pkg::OP_TABLE_FETCH_FINAL_PAGE, 8'h00);
    `CHK({rrd, fpg, rdy}, 3'b110)
    @(negedge i_clk);
    `CHK({we, wd, lat, rdy}, 17'h1bcf5)
    rom = 15'h0155;
    exec(mcu_exec_pkg::OP_TABLE_FETCH_CURRENT_PAGE, 8'h00);
    `CHK({rrd, fpg}, 2'b10)
    @(negedge i_clk);
    `CHK({we, wd, lat}, 16'haa81)
    $display("test table done");
  endtask

  task automatic t_watchdog();
    exec(mcu_exec_pkg::OP_ENTER_POWERDOWN, 8'h00);
    `CHK({hlt, powerdown_flag, exf, wclr, rdy}, 5'b11010)
    @(negedge i_clk);
    `CHK({wclr, rdy}, 2'b00)
    wake = 1'b1;
    @(negedge i_clk);
    wake = 1'b0;
    @(negedge i_clk);
    `CHK({hlt, rdy}, 2'b01)
    tmo = 1'b1;
    @(negedge i_clk);
    tmo = 1'b0;
    `CHK({exf, powerdown_flag}, 2'b11)
    exec(mcu_exec_pkg::OP_WATCHDOG_PRECLEAR_FIRST, 8'h00);
    exec(mcu_exec_pkg::OP_NOP, 8'h00);
    exec(mcu_exec_pkg::OP_WATCHDOG_PRECLEAR_SECOND, 8'h00);
    `CHK({exf, powerdown_flag, wclr}, 3'b110)
    exec(mcu_exec_pkg::OP_NOP, 8'h00);
    exec(mcu_exec_pkg::OP_WATCHDOG_PRECLEAR_FIRST, 8'h00);
    `CHK({exf, powerdown_flag, wclr}, 3'b110)
    exec(mcu_exec_pkg::OP_WATCHDOG_PRECLEAR_SECOND, 8'h00);
    `CHK({exf, powerdown_flag, wclr}, 3'b001)
    tmo = 1'b1;
    @(negedge i_clk);
    tmo = 1'b0;
    exec(mcu_exec_pkg::OP_WATCHDOG_CLEAR_CMD, 8'h00);
    `CHK({exf, powerdown_flag, wclr}, 3'b001)
    $display("test watchdog done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge i_clk);
    i_rst_n = 1'b1;
    t_rotate();
    t_move_bits();
    t_branch();
    t_skip();
    t_table();
    t_watchdog();
    print_verdict();
  end

  // the whole run needs well under 200 cycles
  initial begin
    repeat (3000) @(posedge i_clk);
    miscompares++;
    print_verdict();
  end
endmodule
